// ---- verilog/scrb_regbank.sv ----
// Purpose: Register bank for configuration and status words behind an AXI4-Lite slave
// Assumes: Host keeps valid high until ready; path resets are synchronous to the clock
// Notes: Optional words are decoded only when their build option is set
//
// Overview of operation
// - Status words are read-only; host writes leave them unchanged.
// - Reading a status word returns its value and clears it.
// - Register-interface reset clears all transmit and receive status words.
// - Receive-path reset clears only the receive-side status words.
// - Transmit-path reset clears only the transmit-side status words.
// - Pause configuration and pause status words exist only in the MAC+PCS build.
// - The rate switch word exists only when runtime switching is built.
// - FEC, autoneg, training and user words decode at fixed offsets.
// - Second autoneg link-control status word sits at its own offset.
// - Registers are whole 32-bit aligned words; write strobes are ignored.
// - Unassigned addresses are reserved and answer with an error response.
// - Register-interface reset is asynchronous, active low, forcing defaults.
`timescale 1ns/1ps
`default_nettype none
module scrb_regbank #(
    parameter bit MAC_PCS = 1'b1,            // Combined MAC and PCS build
    parameter bit RATE_SWITCH = 1'b1,        // Runtime rate switching built
    parameter int NCFG = scrb_pkg::N_CFG,    // Configuration word count
    parameter int NSTAT = scrb_pkg::N_STAT   // Status word count
) (
    input wire logic clock_in,                          // Clock
    input wire logic rst_b_in,                          // Async reset, active low
    input wire logic tx_reset_in,                       // Transmit-path reset, high
    input wire logic rx_reset_in,                       // Receive-path reset, high
    input wire logic [NSTAT*32-1:0] stat_set_in,        // Event bits per status word
    output logic [NCFG*32-1:0] cfg_words_out,           // Configuration words
    input wire logic [31:0] s_axi_awaddr_in,            // Write address
    input wire logic s_axi_awvalid_in,                  // Write address valid
    output logic s_axi_awready_out,                     // Write address ready
    input wire logic [31:0] s_axi_wdata_in,             // Write data
    input wire logic [3:0] s_axi_wstrb_in,              // Byte strobes, unused
    input wire logic s_axi_wvalid_in,                   // Write data valid
    output logic s_axi_wready_out,                      // Write data ready
    output logic [1:0] s_axi_bresp_out,                 // Write response
    output logic s_axi_bvalid_out,                      // Write response valid
    input wire logic s_axi_bready_in,                   // Write response ready
    input wire logic [31:0] s_axi_araddr_in,            // Read address
    input wire logic s_axi_arvalid_in,                  // Read address valid
    output logic s_axi_arready_out,                     // Read address ready
    output logic [31:0] s_axi_rdata_out,                // Read data
    output logic [1:0] s_axi_rresp_out,                 // Read response
    output logic s_axi_rvalid_out,                      // Read valid
    input wire logic s_axi_rready_in                    // Read ready
);
    localparam int IW = scrb_pkg::IDX_W;

    scrb_pkg::scrb_dec_s wdec;
    scrb_pkg::scrb_dec_s rdec;
    scrb_pkg::scrb_dec_s rd_dec_q;
    logic aw_rdy_q;
    logic w_rdy_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic ar_rdy_q;
    logic rd_pend_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [31:0] stat_hold_q;
    logic wr_fire;
    logic rd_fire;
    logic cfg_wr_en;
    logic cfg_rd_en;
    logic [31:0] cfg_rd_data;
    logic [31:0] stat_val [NSTAT];
    logic [NSTAT-1:0] stat_clr;

    // Optional words answer as reserved when their option is not built
    function automatic logic cfg_present(input int i);
        logic ok;
        ok = 1'b1;
        if (i >= scrb_pkg::CFG_PAUSE_FIRST && i <= scrb_pkg::CFG_PAUSE_LAST) begin
            ok = MAC_PCS;
        end
        if (i == scrb_pkg::CFG_RATE_IDX) begin
            ok = RATE_SWITCH;
        end
        return ok;
    endfunction

    function automatic logic stat_present(input int i);
        logic ok;
        ok = 1'b1;
        if (i == scrb_pkg::STAT_TX_PAUSE_IDX || i == scrb_pkg::STAT_RX_PAUSE_IDX) begin
            ok = MAC_PCS;
        end
        return ok;
    endfunction

    function automatic scrb_pkg::scrb_dec_s decode(input logic [31:0] addr);
        scrb_pkg::scrb_dec_s d;
        logic in_range;
        d = '0;
        in_range = (addr[31:scrb_pkg::OFFS_W] == '0) && (addr[1:0] == 2'h0);
        for (int i = 0; i < NCFG; i++) begin
            if (in_range && addr[scrb_pkg::OFFS_W-1:0] == scrb_pkg::CFG_OFFS[i]
                && cfg_present(i)) begin
                d.hit = 1'b1;
                d.is_stat = 1'b0;
                d.idx = IW'(i);
            end
        end
        for (int i = 0; i < NSTAT; i++) begin
            if (in_range && addr[scrb_pkg::OFFS_W-1:0] == scrb_pkg::STAT_OFFS[i]
                && stat_present(i)) begin
                d.hit = 1'b1;
                d.is_stat = 1'b1;
                d.idx = IW'(i);
            end
        end
        return d;
    endfunction

    always_comb begin
        wdec = decode(s_axi_awaddr_in);
        rdec = decode(s_axi_araddr_in);
    end

    assign wr_fire = aw_rdy_q && s_axi_awvalid_in && s_axi_wvalid_in;
    assign rd_fire = ar_rdy_q && s_axi_arvalid_in;

    // Write channel: address and data are taken together
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            aw_rdy_q <= 1'b0;
            w_rdy_q <= 1'b0;
        end else if (wr_fire) begin
            aw_rdy_q <= 1'b0;
            w_rdy_q <= 1'b0;
        end else if (s_axi_awvalid_in && s_axi_wvalid_in && !bvalid_q && !aw_rdy_q) begin
            aw_rdy_q <= 1'b1;
            w_rdy_q <= 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bvalid_q <= 1'b0;
            bresp_q <= scrb_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wdec.hit ? scrb_pkg::RESP_OKAY : scrb_pkg::RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready_in) begin
            bvalid_q <= 1'b0;
        end
    end

    assign cfg_wr_en = wr_fire && wdec.hit && !wdec.is_stat;

    // Read channel: one read in flight at a time
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ar_rdy_q <= 1'b0;
        end else if (rd_fire) begin
            ar_rdy_q <= 1'b0;
        end else if (s_axi_arvalid_in && !ar_rdy_q && !rd_pend_q && !rvalid_q) begin
            ar_rdy_q <= 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_pend_q <= 1'b0;
            rd_dec_q <= '0;
            stat_hold_q <= '0;
        end else begin
            rd_pend_q <= rd_fire;
            if (rd_fire) begin
                rd_dec_q <= rdec;
                stat_hold_q <= stat_val[rdec.idx];
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rvalid_q <= 1'b0;
            rresp_q <= scrb_pkg::RESP_OKAY;
            rdata_q <= '0;
        end else if (rd_pend_q) begin
            rvalid_q <= 1'b1;
            if (!rd_dec_q.hit) begin
                rresp_q <= scrb_pkg::RESP_SLVERR;
                rdata_q <= '0;
            end else begin
                rresp_q <= scrb_pkg::RESP_OKAY;
                rdata_q <= rd_dec_q.is_stat ? stat_hold_q : cfg_rd_data;
            end
        end else if (rvalid_q && s_axi_rready_in) begin
            rvalid_q <= 1'b0;
        end
    end

    assign cfg_rd_en = rd_fire && rdec.hit && !rdec.is_stat;

    scrb_cfg_mem #(
        .WORDS(NCFG),
        .WIDTH(32),
        .AW(IW),
        .RESET_VAL(scrb_pkg::CFG_RESET_VAL)
    ) u_cfg_mem (
        .clk_in(clock_in),
        .rst_b_in(rst_b_in),
        .wr_en_in(cfg_wr_en),
        .wr_idx_in(wdec.idx),
        .wr_data_in(s_axi_wdata_in),
        .rd_en_in(cfg_rd_en),
        .rd_idx_in(rdec.idx),
        .rd_data_out(cfg_rd_data),
        .words_out(cfg_words_out)
    );

    genvar g;
    generate
        for (g = 0; g < NSTAT; g++) begin : g_stat
            logic path_rst;
            logic [31:0] set_bits;
            assign path_rst = scrb_pkg::STAT_TX_MASK[g] ? tx_reset_in : rx_reset_in;
            assign set_bits = stat_present(g) ? stat_set_in[g*32 +: 32] : 32'h0000_0000;
            assign stat_clr[g] = rd_fire && rdec.hit && rdec.is_stat && (rdec.idx == IW'(g));
            scrb_stat_word #(
                .WIDTH(32)
            ) u_word (
                .clk_in(clock_in),
                .rst_b_in(rst_b_in),
                .path_reset_in(path_rst),
                .set_in(set_bits),
                .rd_clr_in(stat_clr[g]),
                .value_out(stat_val[g])
            );
        end
    endgenerate

    assign s_axi_awready_out = aw_rdy_q;
    assign s_axi_wready_out = w_rdy_q;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_arready_out = ar_rdy_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rresp_out = rresp_q;
    assign s_axi_rdata_out = rdata_q;
endmodule // scrb_regbank
`default_nettype wire

// ---- verilog/scrb_pkg.sv ----
// Purpose: Shared constants and types for the status and configuration register bank
// Assumes: Register addresses are byte addresses on a 32-bit register port
// Notes: Word lists are indexed in the order the offsets appear below
`default_nettype none
package scrb_pkg;
    localparam int N_CFG = 28;
    localparam int N_STAT = 28;
    localparam int IDX_W = 5;
    localparam int OFFS_W = 12;

    // Configuration word offsets
    localparam logic [11:0] CFG_OFFS [N_CFG] = '{
        12'h090, 12'h094, 12'h098, 12'h09C, 12'h0A0, 12'h0A4, 12'h0A8,
        12'h0AC, 12'h0B0, 12'h0B4, 12'h0B8, 12'h0BC, 12'h0C0, 12'h0C4,
        12'h0D4, 12'h0E0, 12'h0E4, 12'h0F8, 12'h100, 12'h104, 12'h108,
        12'h10C, 12'h110, 12'h114, 12'h130, 12'h134, 12'h138, 12'h13C
    };
    // Pause words span these indices; the rate switch word is the last one
    localparam int CFG_PAUSE_FIRST = 0;
    localparam int CFG_PAUSE_LAST = 13;
    localparam int CFG_RATE_IDX = 27;
    localparam logic [31:0] CFG_RESET_VAL = 32'h0000_0000;

    // Status word offsets
    localparam logic [11:0] STAT_OFFS [N_STAT] = '{
        12'h400, 12'h404, 12'h408, 12'h40C, 12'h410, 12'h414, 12'h418,
        12'h41C, 12'h420, 12'h424, 12'h428, 12'h43C, 12'h440, 12'h448,
        12'h44C, 12'h450, 12'h454, 12'h458, 12'h45C, 12'h460, 12'h9F0,
        12'h464, 12'h468, 12'h46C, 12'h470, 12'h474, 12'h478, 12'h47C
    };
    localparam int STAT_TX_PAUSE_IDX = 15;
    localparam int STAT_RX_PAUSE_IDX = 16;
    // Set bit marks a word cleared by the transmit-path reset
    localparam logic [N_STAT-1:0] STAT_TX_MASK = 28'h000C001;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Result of decoding one address
    typedef struct packed {
        logic hit;
        logic is_stat;
        logic [IDX_W-1:0] idx;
    } scrb_dec_s;
endpackage
`default_nettype wire

// ---- verilog/scrb_cfg_mem.sv ----
// Purpose: Configuration word store with registered read port
// Assumes: One write and one read per cycle at most
// Notes: All words are also presented in parallel to the datapath
`timescale 1ns/1ps
`default_nettype none
module scrb_cfg_mem #(
    parameter int WORDS = 28,
    parameter int WIDTH = 32,
    parameter int AW = 5,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_in,                     // Clock
    input wire logic rst_b_in,                   // Async reset, active low
    input wire logic wr_en_in,                   // Write strobe
    input wire logic [AW-1:0] wr_idx_in,         // Write word index
    input wire logic [WIDTH-1:0] wr_data_in,     // Write data
    input wire logic rd_en_in,                   // Read strobe
    input wire logic [AW-1:0] rd_idx_in,         // Read word index
    output logic [WIDTH-1:0] rd_data_out,        // Registered read data
    output logic [WORDS*WIDTH-1:0] words_out     // All words in parallel
);
    logic [WIDTH-1:0] mem_q [WORDS];
    logic [WIDTH-1:0] rd_q;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < WORDS; i++) begin
                mem_q[i] <= RESET_VAL;
            end
        end else if (wr_en_in) begin
            mem_q[wr_idx_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_q <= '0;
        end else if (rd_en_in) begin
            rd_q <= mem_q[rd_idx_in];
        end
    end

    always_comb begin
        for (int i = 0; i < WORDS; i++) begin
            words_out[i*WIDTH +: WIDTH] = mem_q[i];
        end
    end

    assign rd_data_out = rd_q;
endmodule // scrb_cfg_mem
`default_nettype wire

// ---- verilog/scrb_stat_word.sv ----
// Purpose: One sticky, clear-on-read status word
// Assumes: Set bits are pulses or levels from the datapath, synchronous to the clock
// Notes: A set arriving with the read clear survives into the next read
`timescale 1ns/1ps
`default_nettype none
module scrb_stat_word #(
    parameter int WIDTH = 32
) (
    input wire logic clk_in,                 // Clock
    input wire logic rst_b_in,               // Async reset, active low
    input wire logic path_reset_in,          // Sync path reset, active high
    input wire logic [WIDTH-1:0] set_in,     // Event bits to accumulate
    input wire logic rd_clr_in,              // Read of this word, clears it
    output logic [WIDTH-1:0] value_out       // Accumulated value
);
    logic [WIDTH-1:0] value_q;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            value_q <= '0;
        end else if (path_reset_in) begin
            value_q <= '0;
        end else if (rd_clr_in) begin
            value_q <= set_in;
        end else begin
            value_q <= value_q | set_in;
        end
    end

    assign value_out = value_q;
endmodule // scrb_stat_word
`default_nettype wire

// ---- testbench/scrb_regbank_props.sv ----
// Purpose: Port assertions for the register bank
// Assumes: Default build with both optional word groups present
// Notes: Bound to every scrb_regbank instance
`timescale 1ns/1ps
`default_nettype none
module scrb_regbank_props #(
    parameter int NCFG = 28,
    parameter int NSTAT = 28
) (
    input wire logic clock_in, // Clock
    input wire logic rst_b_in, // Reset
    input wire logic [NCFG*32-1:0] cfg_words_out, // Config words
    input wire logic [31:0] s_axi_awaddr_in, // Write address
    input wire logic s_axi_awvalid_in, // Address valid
    input wire logic s_axi_awready_out, // Address ready
    input wire logic [31:0] s_axi_wdata_in, // Write data
    input wire logic s_axi_wvalid_in, // Data valid
    input wire logic [1:0] s_axi_bresp_out, // Write response
    input wire logic s_axi_bvalid_out, // Response valid
    input wire logic [31:0] s_axi_araddr_in, // Read address
    input wire logic s_axi_arvalid_in, // Read valid
    input wire logic s_axi_arready_out, // Read ready
    input wire logic [31:0] s_axi_rdata_out, // Read data
    input wire logic [1:0] s_axi_rresp_out, // Read response
    input wire logic s_axi_rvalid_out // Data valid
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);
    sequence s_wr;
        s_axi_awready_out && s_axi_awvalid_in && s_axi_wvalid_in;
    endsequence
    sequence s_rd;
        s_axi_arready_out && s_axi_arvalid_in;
    endsequence
    sequence s_rd_ans(logic [1:0] r);
        ##2 (s_axi_rvalid_out && s_axi_rresp_out == r);
    endsequence
    property p_status_ro;
        (s_wr ##0 s_axi_awaddr_in[31:8] == 24'h000004) |=> $stable(cfg_words_out);
    endproperty
    property p_fec_wr;
        (s_wr ##0 s_axi_awaddr_in == 32'h0000_00D4)
            |=> cfg_words_out[479:448] == $past(s_axi_wdata_in);
    endproperty
    property p_user_wr;
        (s_wr ##0 s_axi_awaddr_in == 32'h0000_0138)
            |=> cfg_words_out[863:832] == $past(s_axi_wdata_in);
    endproperty
    property p_rate_wr;
        (s_wr ##0 s_axi_awaddr_in == 32'h0000_013C)
            |=> cfg_words_out[895:864] == $past(s_axi_wdata_in);
    endproperty
    property p_wr_rsv;
        (s_wr ##0 (s_axi_awaddr_in[31:12] != 20'h0 || s_axi_awaddr_in[1:0] != 2'h0))
            |=> s_axi_bvalid_out && s_axi_bresp_out == 2'h2;
    endproperty
    property p_rd_rsv;
        (s_rd ##0 (s_axi_araddr_in[31:12] != 20'h0 || s_axi_araddr_in[1:0] != 2'h0))
            |-> s_rd_ans(2'h2) ##0 s_axi_rdata_out == 32'h0;
    endproperty
    property p_pause_rd;
        (s_rd ##0 s_axi_araddr_in == 32'h0000_0450) |-> s_rd_ans(2'h0);
    endproperty
    property p_link2_rd;
        (s_rd ##0 s_axi_araddr_in == 32'h0000_09F0) |-> s_rd_ans(2'h0);
    endproperty
    property p_reset_zero;
        $rose(rst_b_in) |-> cfg_words_out == '0 && !s_axi_bvalid_out && !s_axi_rvalid_out;
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write altered config");
    a_fec_wr: assert property (p_fec_wr) else $error("fec word not written");
    a_user_wr: assert property (p_user_wr) else $error("user word not whole");
    a_rate_wr: assert property (p_rate_wr) else $error("rate word not written");
    a_wr_rsv: assert property (p_wr_rsv) else $error("reserved write not refused");
    a_rd_rsv: assert property (p_rd_rsv) else $error("reserved read not refused");
    a_pause_rd: assert property (p_pause_rd) else $error("pause status missing");
    a_link2_rd: assert property (p_link2_rd) else $error("link control word missing");
    a_reset_zero: assert property (p_reset_zero) else $error("state not reset");
endmodule // scrb_regbank_props
bind scrb_regbank scrb_regbank_props #(.NCFG(NCFG), .NSTAT(NSTAT)) i_scrb_regbank_props (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .cfg_words_out(cfg_words_out),
    .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wdata_in(s_axi_wdata_in),
    .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_araddr_in(s_axi_araddr_in),
    .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
    .s_axi_rvalid_out(s_axi_rvalid_out));
`default_nettype wire

// ---- testbench/scrb_host_model.sv ----
// Purpose: Host master issuing single register reads and writes
// Assumes: Requests start just after an edge and hold until ready
// Notes: Released lines except the strobes show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module scrb_host_model (
    input wire logic clk_in, // Clock
    output logic [31:0] awaddr_out, // Write address
    output logic awvalid_out, // Address valid
    input wire logic awready_in, // Address ready
    output logic [31:0] wdata_out, // Write data
    output logic [3:0] wstrb_out, // Strobes
    output logic wvalid_out, // Data valid
    input wire logic wready_in, // Data ready
    input wire logic [1:0] bresp_in, // Response
    input wire logic bvalid_in, // Response valid
    output logic bready_out, // Response ready
    output logic [31:0] araddr_out, // Read address
    output logic arvalid_out, // Read valid
    input wire logic arready_in, // Read ready
    input wire logic [31:0] rdata_in, // Read data
    input wire logic [1:0] rresp_in, // Read response
    input wire logic rvalid_in, // Data valid
    output logic rready_out // Data ready
);
    int hangs = 0;
    initial begin
        {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out} = '0;
        {araddr_out, arvalid_out, rready_out} = '0;
    end
    function automatic logic flag(input int w);
        case (w)
            0: return awready_in && wready_in;
            1: return bvalid_in;
            2: return arready_in;
            default: return rvalid_in;
        endcase
    endfunction
    // Bounded wait for a flag sampled high at an edge
    task automatic wait_hi(input int w);
        for (int k = 0; k < 40; k++) begin
            @(posedge clk_in);
            if (flag(w) === 1'b1) return;
        end
        hangs++;
    endtask
    task automatic write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
        input int lag, output logic [1:0] r);
        @(posedge clk_in);
        #1;
        {awaddr_out, wdata_out, wstrb_out, awvalid_out, wvalid_out} = {a, d, s, 2'b11};
        wait_hi(0);
        #1;
        {awaddr_out, wdata_out, awvalid_out, wvalid_out} = {~a, ~d, 2'b00};
        repeat (lag) @(posedge clk_in);
        #1;
        bready_out = 1'b1;
        wait_hi(1);
        r = bresp_in;
        #1;
        bready_out = 1'b0;
    endtask
    task automatic read(input logic [31:0] a, input int lag, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge clk_in);
        #1;
        {araddr_out, arvalid_out} = {a, 1'b1};
        wait_hi(2);
        #1;
        {araddr_out, arvalid_out} = {~a, 1'b0};
        repeat (lag) @(posedge clk_in);
        #1;
        rready_out = 1'b1;
        wait_hi(3);
        d = rdata_in;
        r = rresp_in;
        #1;
        rready_out = 1'b0;
    endtask
endmodule // scrb_host_model
`default_nettype wire

// ---- testbench/scrb_regbank_tb.sv ----
// Purpose: Self-checking bench for the register bank
// Assumes: Default build with both optional word groups
// Notes: A bench model of every word predicts each answer
`timescale 1ns/1ps
`default_nettype none
module scrb_regbank_tb;
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic tx_reset_in = 1'b0;
    logic rx_reset_in = 1'b0;
    logic [895:0] stat_set = '0;
    logic [895:0] cfg_words;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] m_cfg [28];
    logic [31:0] m_stat [28];
    logic [31:0] seed = 32'hEEF9993E;
    logic [31:0] rsv [$] = '{32'h0000_00C8, 32'h0000_013A, 32'h0000_0500, 32'h1000_0400};
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    always #50 clock_in = ~clock_in;
    scrb_regbank i_scrb_regbank (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .tx_reset_in(tx_reset_in), .rx_reset_in(rx_reset_in), .stat_set_in(stat_set),
        .cfg_words_out(cfg_words), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
    scrb_host_model i_scrb_host_model (.clk_in(clock_in), .wready_in(wready), .awaddr_out(awaddr),
        .awvalid_out(awvalid), .awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb),
        .wvalid_out(wvalid), .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready),
        .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata),
        .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int find(input logic [31:0] a, input bit st);
        for (int i = 0; i < 28; i++) begin
            if (a === {20'h0, st ? scrb_pkg::STAT_OFFS[i] : scrb_pkg::CFG_OFFS[i]}) return i;
        end
        return -1;
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (exp !== got) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [31:0] a);
        logic [31:0] d;
        logic [1:0] r;
        int ci;
        int si;
        ci = find(a, 1'b0);
        si = find(a, 1'b1);
        i_scrb_host_model.read(a, int'(rnd() % 3), d, r);
        if (ci >= 0) begin
            chk("config read", m_cfg[ci], d);
            chk("config port", m_cfg[ci], cfg_words[ci*32+:32]);
        end else if (si >= 0) begin
            chk("status read", m_stat[si], d);
            m_stat[si] = stat_set[si*32+:32];
        end else begin
            chk("reserved data", 32'h0, d);
        end
        chk("read resp", (ci < 0 && si < 0) ? 32'h2 : 32'h0, {30'h0, r});
    endtask
    task automatic wr_chk(input logic [31:0] a, input logic [31:0] d);
        logic [1:0] r;
        logic [31:0] s;
        int ci;
        ci = find(a, 1'b0);
        s = rnd();
        i_scrb_host_model.write(a, d, s[3:0], int'(s[9:8]), r);
        if (ci >= 0) m_cfg[ci] = d;
        chk("write resp", (ci < 0 && find(a, 1'b1) < 0) ? 32'h2 : 32'h0, {30'h0, r});
    endtask
    task automatic rd_all();
        for (int i = 0; i < 28; i++) rd_chk({20'h0, scrb_pkg::CFG_OFFS[i]});
        for (int i = 0; i < 28; i++) rd_chk({20'h0, scrb_pkg::STAT_OFFS[i]});
    endtask
    task automatic pulse_all();
        logic [31:0] v;
        @(posedge clock_in);
        #1;
        for (int i = 0; i < 28; i++) begin
            v = rnd();
            stat_set[i*32+:32] = v;
            m_stat[i] |= v;
        end
        @(posedge clock_in);
        #1;
        stat_set = '0;
    endtask
    task automatic test_done();
        errors += i_scrb_host_model.hangs;
        $display("Checks run %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 12000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        foreach (m_cfg[i]) {m_cfg[i], m_stat[i]} = '0;
        repeat (12) @(posedge clock_in);
        #1;
        rst_b_in = 1'b1;
        repeat (2) @(posedge clock_in);
        rd_all();
        for (int i = 0; i < 28; i++) wr_chk({20'h0, scrb_pkg::CFG_OFFS[i]}, rnd());
        rd_all();
        pulse_all();
        for (int i = 0; i < 28; i++) wr_chk({20'h0, scrb_pkg::STAT_OFFS[i]}, rnd());
        rd_all();
        rd_all();
        foreach (rsv[i]) wr_chk(rsv[i], rnd());
        foreach (rsv[i]) rd_chk(rsv[i]);
        // Event held across the clearing read
        stat_set[127:96] = 32'hA5A5_0F0F;
        m_stat[3] = 32'hA5A5_0F0F;
        rd_chk(32'h0000_040C);
        stat_set = '0;
        rd_chk(32'h0000_040C);
        rd_chk(32'h0000_040C);
        for (int p = 0; p < 2; p++) begin
            pulse_all();
            {tx_reset_in, rx_reset_in} = (p == 0) ? 2'b10 : 2'b01;
            @(posedge clock_in);
            #1;
            {tx_reset_in, rx_reset_in} = 2'b00;
            for (int i = 0; i < 28; i++) if (scrb_pkg::STAT_TX_MASK[i] == (p == 0)) m_stat[i] = '0;
            rd_all();
        end
        pulse_all();
        @(posedge clock_in);
        #1;
        rst_b_in = 1'b0;
        foreach (m_cfg[i]) {m_cfg[i], m_stat[i]} = '0;
        repeat (3) @(posedge clock_in);
        #1;
        rst_b_in = 1'b1;
        repeat (2) @(posedge clock_in);
        rd_all();
        test_done();
    end
endmodule // scrb_regbank_tb
`default_nettype wire
